// ### ddrh_port.sv
// AXI4 data port and Wishbone configuration port of the DRAM controller
// Functional notes
// - Write address taken when awvalid and awready
// - Write burst beats equal awlen plus one
// - Read address taken when arvalid and arready
// - Read burst beats equal arlen plus one
// - Write beat counts only with wready high
// - Read beats flagged valid, last beat flagged
// - Config access takes at least two cycles
// - Config access completes on request plus ready
// - Config read data valid at completion only
// - State change applied only between bursts
// - Address split row-bank-column or bank-row-column
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "ddrh_defs.svh"
module ddrh_port #(
  parameter int ID_W = 4,
  parameter int COL_W = 3,
  parameter int BANK_W = 1,
  parameter int ROW_W = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // AXI write address
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_awaddr,
  input wire logic [ID_W-1:0] i_axi_awid,
  input wire logic [7:0] i_axi_awlen,
  // AXI write data
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wlast,
  // AXI write response, never raised
  output logic o_axi_bvalid,
  output logic [ID_W-1:0] o_axi_bid,
  output logic [1:0] o_axi_bresp,
  input wire logic i_axi_bready,
  // AXI read address
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  input wire logic [31:0] i_axi_araddr,
  input wire logic [ID_W-1:0] i_axi_arid,
  input wire logic [7:0] i_axi_arlen,
  // AXI read data
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  output logic [31:0] o_axi_rdata,
  output logic [ID_W-1:0] o_axi_rid,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rlast,
  // Wishbone configuration slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // DRAM state and mode-register load
  output logic [1:0] o_dram_state,
  output logic o_mr_load
);
  localparam int MEM_AW = COL_W + BANK_W + ROW_W;
  localparam int DEPTH = 1 << MEM_AW;
  localparam int APPLY_CYC = (`DDRH_T_SWITCH_NS * `DDRH_CLK_MHZ + 999) / 1000;

  logic [31:0] mem [DEPTH];

  // Byte address to storage index, honouring the mapping order
  function automatic logic [MEM_AW-1:0] map_idx(input logic [31:0] a, input logic bank_first);
    logic [MEM_AW-1:0] w;
    logic [COL_W-1:0] col;
    logic [BANK_W-1:0] bank;
    logic [ROW_W-1:0] row;
    w = a[MEM_AW+1:2];
    col = w[COL_W-1:0];
    if (bank_first)
    begin
      row = w[COL_W +: ROW_W];
      bank = w[COL_W+ROW_W +: BANK_W];
    end
    else
    begin
      bank = w[COL_W +: BANK_W];
      row = w[COL_W+BANK_W +: ROW_W];
    end
    map_idx = {bank, row, col};
  endfunction

  // Byte-lane merge for register and storage writes
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        merge[8*i +: 8] = n[8*i +: 8];
  endfunction

  // AXI channel state
  logic w_act_reg, w_act_next, r_act_reg, r_act_next;
  logic [31:0] w_addr_reg, w_addr_next, r_addr_reg, r_addr_next;
  logic [7:0] w_len_reg, w_len_next, w_cnt_reg, w_cnt_next;
  logic [7:0] r_len_reg, r_len_next, r_cnt_reg, r_cnt_next;
  logic [ID_W-1:0] r_id_reg, r_id_next;
  logic [31:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next, rlast_reg, rlast_next;
  // Configuration registers
  logic [15:0] mr_reg [4];
  logic [15:0] mr_next [4];
  logic cfg_map_reg, cfg_map_next;
  ddrh_pkg::ddrh_dram_e req_reg, req_next;
  logic ack_reg, ack_next;
  logic [31:0] wbdat_reg, wbdat_next;
  logic trig;
  // Switcher status
  ddrh_pkg::ddrh_dram_e sw_state;
  logic sw_ack, sw_busy;
  logic open_gate, w_beat, r_beat, wb_req;
  logic [31:0] rd_word;

  ddrh_state_sw #(
    .APPLY_CYC(APPLY_CYC)
  ) u_sw (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_trig(trig),
    .i_req(req_next),
    .i_bus_idle(!w_act_reg && !r_act_reg),
    .o_state(sw_state),
    .o_ack(sw_ack),
    .o_busy(sw_busy),
    .o_mr_load(o_mr_load)
  );

  // New bursts start only in the active state with no switch pending
  assign open_gate = (sw_state == ddrh_pkg::DDRH_ST_ACTIVE) && !sw_busy;
  assign o_axi_awready = open_gate && !w_act_reg;
  assign o_axi_arready = open_gate && !r_act_reg;
  assign o_axi_wready = w_act_reg;
  assign w_beat = w_act_reg && i_axi_wvalid;
  assign r_beat = rvalid_reg && i_axi_rready;
  assign rd_word = mem[map_idx(r_addr_reg + 32'h4, cfg_map_reg)];

  always_comb
  begin
    w_act_next = w_act_reg;
    w_addr_next = w_addr_reg;
    w_len_next = w_len_reg;
    w_cnt_next = w_cnt_reg;
    r_act_next = r_act_reg;
    r_addr_next = r_addr_reg;
    r_len_next = r_len_reg;
    r_cnt_next = r_cnt_reg;
    r_id_next = r_id_reg;
    rdata_next = rdata_reg;
    rvalid_next = rvalid_reg;
    rlast_next = rlast_reg;
    if (i_axi_awvalid && o_axi_awready)
    begin
      w_act_next = 1'b1;
      w_addr_next = i_axi_awaddr;
      w_len_next = i_axi_awlen;
      w_cnt_next = 8'h00;
    end
    else if (w_beat)
    begin
      w_addr_next = w_addr_reg + 32'h4;
      w_cnt_next = w_cnt_reg + 8'h01;
      if (w_cnt_reg == w_len_reg)
        w_act_next = 1'b0;
    end
    if (i_axi_arvalid && o_axi_arready)
    begin
      r_act_next = 1'b1;
      r_addr_next = i_axi_araddr;
      r_len_next = i_axi_arlen;
      r_cnt_next = 8'h00;
      r_id_next = i_axi_arid;
      rdata_next = mem[map_idx(i_axi_araddr, cfg_map_reg)];
      rvalid_next = 1'b1;
      rlast_next = (i_axi_arlen == 8'h00);
    end
    else if (r_beat)
    begin
      if (r_cnt_reg == r_len_reg)
      begin
        r_act_next = 1'b0;
        rvalid_next = 1'b0;
        rlast_next = 1'b0;
      end
      else
      begin
        r_addr_next = r_addr_reg + 32'h4;
        r_cnt_next = r_cnt_reg + 8'h01;
        rdata_next = rd_word;
        rlast_next = (r_cnt_reg + 8'h01 == r_len_reg);
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      w_act_reg <= 1'b0;
      w_addr_reg <= 32'h0;
      w_len_reg <= 8'h00;
      w_cnt_reg <= 8'h00;
      r_act_reg <= 1'b0;
      r_addr_reg <= 32'h0;
      r_len_reg <= 8'h00;
      r_cnt_reg <= 8'h00;
      r_id_reg <= '0;
      rdata_reg <= 32'h0;
      rvalid_reg <= 1'b0;
      rlast_reg <= 1'b0;
    end
    else
    begin
      w_act_reg <= w_act_next;
      w_addr_reg <= w_addr_next;
      w_len_reg <= w_len_next;
      w_cnt_reg <= w_cnt_next;
      r_act_reg <= r_act_next;
      r_addr_reg <= r_addr_next;
      r_len_reg <= r_len_next;
      r_cnt_reg <= r_cnt_next;
      r_id_reg <= r_id_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      rlast_reg <= rlast_next;
    end
  end

  // Storage written per strobed byte lane with the beat
  always_ff @(posedge i_clk_sys)
  begin
    if (w_beat)
      mem[map_idx(w_addr_reg, cfg_map_reg)] <=
        merge(mem[map_idx(w_addr_reg, cfg_map_reg)], i_axi_wdata, i_axi_wstrb);
  end

  assign o_axi_rvalid = rvalid_reg;
  assign o_axi_rdata = rdata_reg;
  assign o_axi_rid = r_id_reg;
  assign o_axi_rresp = 2'h0;
  assign o_axi_rlast = rlast_reg;
  assign o_axi_bvalid = 1'b0;
  assign o_axi_bid = '0;
  assign o_axi_bresp = 2'h0;

  // Configuration slave: ack one cycle after the request, write at ack edge
  assign wb_req = i_wb_cyc && i_wb_stb;
  assign trig = wb_req && i_wb_we && ack_reg && (i_wb_adr == `DDRH_OFS_CTRL) &&
                i_wb_sel[0] && i_wb_sel[1] && i_wb_dat[`DDRH_CTRL_TRIG];

  always_comb
  begin
    ack_next = wb_req && !ack_reg;
    wbdat_next = wbdat_reg;
    cfg_map_next = cfg_map_reg;
    req_next = req_reg;
    for (int i = 0; i < 4; i++)
      mr_next[i] = mr_reg[i];
    if (wb_req && !ack_reg && !i_wb_we)
    begin
      case (i_wb_adr)
        `DDRH_OFS_CTRL: wbdat_next = 32'({req_reg, 14'h0000});
        `DDRH_OFS_STATUS: wbdat_next = 32'({sw_state, sw_busy, sw_ack});
        `DDRH_OFS_MR0: wbdat_next = 32'(mr_reg[0]);
        `DDRH_OFS_MR1: wbdat_next = 32'(mr_reg[1]);
        `DDRH_OFS_MR2: wbdat_next = 32'(mr_reg[2]);
        `DDRH_OFS_MR3: wbdat_next = 32'(mr_reg[3]);
        `DDRH_OFS_CFG: wbdat_next = 32'(cfg_map_reg);
        default: wbdat_next = 32'h0;
      endcase
    end
    if (wb_req && i_wb_we && ack_reg)
    begin
      case (i_wb_adr)
        `DDRH_OFS_CTRL:
        begin
          if (i_wb_sel[1])
            req_next = ddrh_pkg::ddrh_dram_e'(i_wb_dat[`DDRH_CTRL_REQ_LSB +: 2]);
        end
        `DDRH_OFS_MR0: mr_next[0] = 16'(merge(32'(mr_reg[0]), i_wb_dat, i_wb_sel));
        `DDRH_OFS_MR1: mr_next[1] = 16'(merge(32'(mr_reg[1]), i_wb_dat, i_wb_sel));
        `DDRH_OFS_MR2: mr_next[2] = 16'(merge(32'(mr_reg[2]), i_wb_dat, i_wb_sel));
        `DDRH_OFS_MR3: mr_next[3] = 16'(merge(32'(mr_reg[3]), i_wb_dat, i_wb_sel));
        `DDRH_OFS_CFG:
        begin
          if (i_wb_sel[0])
            cfg_map_next = i_wb_dat[`DDRH_CFG_MAP];
        end
        default: cfg_map_next = cfg_map_reg;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      ack_reg <= 1'b0;
      wbdat_reg <= 32'h0;
      cfg_map_reg <= `DDRH_CFG_RST;
      req_reg <= ddrh_pkg::DDRH_ST_ACTIVE;
      for (int i = 0; i < 4; i++)
        mr_reg[i] <= `DDRH_MR_RST;
    end
    else
    begin
      ack_reg <= ack_next;
      wbdat_reg <= wbdat_next;
      cfg_map_reg <= cfg_map_next;
      req_reg <= req_next;
      for (int i = 0; i < 4; i++)
        mr_reg[i] <= mr_next[i];
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = wbdat_reg;
  assign o_dram_state = sw_state;
endmodule

// ### ddrh_defs.svh
// Register offsets, field positions, reset values, clock rate in MHz and switch time in ns of the host port
`ifndef DDRH_DEFS_SVH
`define DDRH_DEFS_SVH
`define DDRH_OFS_CTRL 8'h00
`define DDRH_OFS_STATUS 8'h04
`define DDRH_OFS_MR0 8'h08
`define DDRH_OFS_MR1 8'h0c
`define DDRH_OFS_MR2 8'h10
`define DDRH_OFS_MR3 8'h14
`define DDRH_OFS_CFG 8'h18
`define DDRH_CTRL_TRIG 0
`define DDRH_CTRL_REQ_LSB 14
`define DDRH_STAT_ACK 0
`define DDRH_STAT_BUSY 1
`define DDRH_STAT_STATE_LSB 2
`define DDRH_CFG_MAP 0
`define DDRH_MR_RST 16'h0000
`define DDRH_CFG_RST 1'b0
`define DDRH_CLK_MHZ 25
`define DDRH_T_SWITCH_NS 200
`endif

// ### ddrh_pkg.sv
// Types shared by the host port and its state switcher
package ddrh_pkg;
  typedef enum logic [1:0] {
    DDRH_ST_ACTIVE = 2'h0,
    DDRH_ST_PDOWN = 2'h1,
    DDRH_ST_SREF = 2'h2,
    DDRH_ST_MRS = 2'h3
  } ddrh_dram_e;
  typedef enum logic [1:0] {
    DDRH_SW_IDLE = 2'h0,
    DDRH_SW_WAIT = 2'h1,
    DDRH_SW_APPLY = 2'h3
  } ddrh_sw_e;
endpackage

// ### ddrh_state_sw.sv
// DRAM state switcher: applies requested state changes at safe points
`timescale 1ns/100ps
module ddrh_state_sw #(
  parameter int APPLY_CYC = 5
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Request side
  input wire logic i_trig,
  input wire ddrh_pkg::ddrh_dram_e i_req,
  input wire logic i_bus_idle,
  // Status side
  output ddrh_pkg::ddrh_dram_e o_state,
  output logic o_ack,
  output logic o_busy,
  output logic o_mr_load
);
  ddrh_pkg::ddrh_sw_e sw_reg, sw_next;
  ddrh_pkg::ddrh_dram_e state_reg, state_next, req_reg, req_next;
  logic ack_reg, ack_next, mrl_reg, mrl_next;
  logic [7:0] cnt_reg, cnt_next;

  always_comb
  begin
    sw_next = sw_reg;
    state_next = state_reg;
    req_next = req_reg;
    ack_next = ack_reg;
    cnt_next = cnt_reg;
    mrl_next = 1'b0;
    case (sw_reg)
      ddrh_pkg::DDRH_SW_IDLE:
      begin
        if (i_trig)
        begin
          req_next = i_req;
          ack_next = 1'b0;
          sw_next = ddrh_pkg::DDRH_SW_WAIT;
        end
      end
      ddrh_pkg::DDRH_SW_WAIT:
      begin
        // Hold off until no burst is in flight
        if (i_bus_idle)
        begin
          sw_next = ddrh_pkg::DDRH_SW_APPLY;
          cnt_next = 8'h00;
        end
      end
      ddrh_pkg::DDRH_SW_APPLY:
      begin
        if (cnt_reg == 8'(APPLY_CYC - 1))
        begin
          sw_next = ddrh_pkg::DDRH_SW_IDLE;
          ack_next = 1'b1;
          if (req_reg == ddrh_pkg::DDRH_ST_MRS)
            mrl_next = 1'b1;
          else
            state_next = req_reg;
        end
        else
          cnt_next = cnt_reg + 8'h01;
      end
      default: sw_next = ddrh_pkg::DDRH_SW_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      sw_reg <= ddrh_pkg::DDRH_SW_IDLE;
      state_reg <= ddrh_pkg::DDRH_ST_ACTIVE;
      req_reg <= ddrh_pkg::DDRH_ST_ACTIVE;
      ack_reg <= 1'b1;
      cnt_reg <= 8'h00;
      mrl_reg <= 1'b0;
    end
    else
    begin
      sw_reg <= sw_next;
      state_reg <= state_next;
      req_reg <= req_next;
      ack_reg <= ack_next;
      cnt_reg <= cnt_next;
      mrl_reg <= mrl_next;
    end
  end

  assign o_state = state_reg;
  assign o_ack = ack_reg;
  assign o_busy = (sw_reg != ddrh_pkg::DDRH_SW_IDLE);
  assign o_mr_load = mrl_reg;
endmodule

// ### ddrh_port_chk.sv
// Concurrent checks on the host port pins
`timescale 1ns/100ps
module ddrh_port_chk (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Data port
  input wire logic i_axi_awvalid,
  input wire logic o_axi_awready,
  input wire logic [7:0] i_axi_awlen,
  input wire logic i_axi_wvalid,
  input wire logic o_axi_wready,
  input wire logic i_axi_arvalid,
  input wire logic o_axi_arready,
  input wire logic [7:0] i_axi_arlen,
  input wire logic o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic o_axi_rlast,
  // Configuration port and state
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic [1:0] o_dram_state
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  logic [7:0] wcnt_reg, wcnt_next, rcnt_reg, rcnt_next;
  wire w_hs = i_axi_wvalid && o_axi_wready;
  wire r_hs = o_axi_rvalid && i_axi_rready;
  wire w_end = w_hs && wcnt_reg == 8'h00;
  // Beats left after the current one in the open bursts
  always_comb
  begin
    wcnt_next = i_axi_awvalid && o_axi_awready ? i_axi_awlen : wcnt_reg - {7'h00, w_hs};
    rcnt_next = i_axi_arvalid && o_axi_arready ? i_axi_arlen : rcnt_reg - {7'h00, r_hs};
  end
  always_ff @(posedge i_clk_sys)
  begin
    wcnt_reg <= i_nrst ? wcnt_next : 8'h00;
    rcnt_reg <= i_nrst ? rcnt_next : 8'h00;
  end
  chk_aw_wready: assert property (i_axi_awvalid && o_axi_awready |=> o_axi_wready)
    else $error("no wready after aw");
  chk_w_end: assert property (w_end |=> !o_axi_wready)
    else $error("write burst too long");
  chk_w_hold: assert property (o_axi_wready && !w_end |=> o_axi_wready)
    else $error("write burst too short");
  chk_ar_rvalid: assert property (i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
    else $error("no rvalid after ar");
  chk_rlast_pos: assert property (o_axi_rvalid |-> o_axi_rlast == (rcnt_reg == 8'h00))
    else $error("rlast misplaced");
  chk_r_end: assert property (r_hs && o_axi_rlast |=> !o_axi_rvalid)
    else $error("rvalid after last");
  chk_r_run: assert property (r_hs && !o_axi_rlast |=> o_axi_rvalid)
    else $error("read burst broken");
  chk_wb_ack: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("ack late");
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  chk_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  chk_busy_block: assert property (o_axi_awready || o_axi_arready |-> o_dram_state == 2'h0)
    else $error("address ready outside active state");
  chk_state_hold: assert property (o_axi_wready || o_axi_rvalid |=> $stable(o_dram_state))
    else $error("state moved in burst");
  cover property (w_end);
  cover property (r_hs && o_axi_rlast);
  cover property ($changed(o_dram_state));
endmodule
bind ddrh_port ddrh_port_chk u_chk (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready), .i_axi_awlen(i_axi_awlen),
  .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .i_axi_arvalid(i_axi_arvalid),
  .o_axi_arready(o_axi_arready), .i_axi_arlen(i_axi_arlen), .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready), .o_axi_rlast(o_axi_rlast), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_dram_state(o_dram_state));

// ### ddrh_axi_mst.sv
// AXI4 master model for the host data port
`timescale 1ns/100ps
module ddrh_axi_mst (
  // Clock and answers
  input wire logic i_clk,
  input wire logic i_awready,
  input wire logic i_wready,
  input wire logic i_arready,
  input wire logic i_rvalid,
  input wire logic i_rlast,
  // Requests
  output logic o_awvalid,
  output logic [31:0] o_awaddr,
  output logic [7:0] o_awlen,
  output logic o_wvalid,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wlast,
  output logic o_arvalid,
  output logic [31:0] o_araddr,
  output logic [7:0] o_arlen,
  output logic o_rready
);
  logic [31:0] wd [8];
  logic [3:0] ws [8];
  logic slow = 1'b0;
  logic tmo = 1'b0;
  int k;
  initial
  begin
    {o_awvalid, o_wvalid, o_wlast, o_arvalid, o_wstrb} = 8'h00;
    {o_awaddr, o_araddr, o_wdata, o_awlen, o_arlen} = 112'h0;
    o_rready = 1'b1;
  end
  // Addresses and write data held until taken, then scrambled so stale values cannot pass
  task wr(input logic [31:0] a, input logic [7:0] n);
    o_awaddr <= a;
    o_awlen <= n;
    o_awvalid <= 1'b1;
    k = 0;
    do @(posedge i_clk); while (!i_awready && ++k < 99);
    o_awvalid <= 1'b0;
    o_awaddr <= ~a;
    for (int b = 0; b <= n; b++)
    begin
      if (slow)
      begin
        o_wvalid <= 1'b0;
        o_wdata <= ~o_wdata;
        @(posedge i_clk);
      end
      o_wvalid <= 1'b1;
      o_wdata <= wd[b];
      o_wstrb <= ws[b];
      o_wlast <= b == n;
      do @(posedge i_clk); while (!i_wready && ++k < 99);
    end
    o_wvalid <= 1'b0;
    o_wlast <= 1'b0;
    o_wdata <= ~o_wdata;
    tmo |= k >= 99;
  endtask
  task rd(input logic [31:0] a, input logic [7:0] n);
    o_araddr <= a;
    o_arlen <= n;
    o_arvalid <= 1'b1;
    k = 0;
    do @(posedge i_clk); while (!i_arready && ++k < 99);
    o_arvalid <= 1'b0;
    o_araddr <= ~a;
    do @(posedge i_clk); while (!(i_rvalid && i_rlast) && ++k < 99);
    tmo |= k >= 99;
  endtask
endmodule

// ### ddrh_tb.sv
// Self-checking bench for the host data and configuration port
`timescale 1ns/100ps
`include "ddrh_defs.svh"
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, wb_q, v, seed = 32'h48d7936b;
  logic [31:0] mem [64];
  logic [32:0] exp_q [$];
  logic [1:0] rq [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic [1:0] e, ps = 2'h0;
  logic wb_chk = 1'b0;
  int n_mismatch = 0, samples_checked = 0, n_mrl = 0, k, p, a, n;
  wire awv, awr, wv, wrd, wl, arv, arr, rv, rr, rl, ack, mrl;
  wire [31:0] awa, wd, ara, rdat, wbd;
  wire [7:0] awn, arn;
  wire [3:0] ws;
  wire [1:0] st;
  wire [1:0] rrs;
  wire [3:0] rid;
  wire bv;
  logic [3:0] aid = 4'h5;
  initial forever #20 clk = ~clk;
  ddrh_port uut (.i_clk_sys(clk), .i_nrst(nrst),
    .i_axi_awvalid(awv), .o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_awid(4'h3),
    .i_axi_awlen(awn), .i_axi_wvalid(wv), .o_axi_wready(wrd), .i_axi_wdata(wd),
    .i_axi_wstrb(ws), .i_axi_wlast(wl), .o_axi_bvalid(bv), .o_axi_bid(), .o_axi_bresp(),
    .i_axi_bready(1'b0),
    .i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara), .i_axi_arid(aid),
    .i_axi_arlen(arn), .o_axi_rvalid(rv), .i_axi_rready(rr), .o_axi_rdata(rdat),
    .o_axi_rid(rid), .o_axi_rresp(rrs), .o_axi_rlast(rl), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(wbd),
    .o_wb_ack(ack), .o_dram_state(st), .o_mr_load(mrl));
  ddrh_axi_mst mst (.i_clk(clk), .i_awready(awr), .i_wready(wrd), .i_arready(arr),
    .i_rvalid(rv), .i_rlast(rl), .o_awvalid(awv), .o_awaddr(awa), .o_awlen(awn),
    .o_wvalid(wv), .o_wdata(wd), .o_wstrb(ws), .o_wlast(wl), .o_arvalid(arv),
    .o_araddr(ara), .o_arlen(arn), .o_rready(rr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [32:0] got);
    logic [32:0] x;
    x = exp_q.pop_front();
    samples_checked++;
    if (got !== x)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] x);
    exp_q.push_back(x);
    cmp(got);
  endtask
  // Results are compared in the cycle their handshake completes
  always @(posedge clk)
  begin
    if (rv && rr)
      cmp({rl, rdat});
    // Read ID returned with every beat, response always okay
    if (rv && rr && {rid, rrs} !== {aid, 2'h0})
    begin
      n_mismatch++;
      $display("BAD t=%0t rid=%h exp=%h", $time, {rid, rrs}, {aid, 2'h0});
    end
    if (bv !== 1'b0)
    begin
      n_mismatch++;
      $display("BAD t=%0t bvalid=%h exp=%h", $time, bv, 1'b0);
    end
    if (ack && wb_chk)
      cmp({1'b0, wbd});
    if (mrl)
      n_mrl++;
  end
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    dat <= d;
    sel <= s;
    k = 0;
    do @(posedge clk); while (!ack && ++k < 20);
    wb_q = wbd;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d;
    @(posedge clk);
    if (k >= 20)
      n_mismatch++;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] x);
    exp_q.push_back({1'b0, x});
    wb_chk = 1'b1;
    wb(1'b0, ad, 32'h0, 4'hf);
    wb_chk = 1'b0;
  endtask
  task automatic axw(input logic full);
    for (int b = 0; b <= n; b++)
    begin
      v = rnd();
      mst.wd[b] = v;
      mst.ws[b] = full ? 4'hf : v[7:4];
      for (int j = 0; j < 4; j++)
        if (mst.ws[b][j])
          mem[a + b][8*j +: 8] = v[8*j +: 8];
    end
    mst.wr({24'h0, a[5:0], 2'b00}, n[7:0]);
  endtask
  task automatic axr();
    aid <= 4'(a + n);
    for (int b = 0; b <= n; b++)
      exp_q.push_back({b == n, mem[a + b]});
    mst.rd({24'h0, a[5:0], 2'b00}, n[7:0]);
  endtask
  task end_of_test();
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdc(`DDRH_OFS_STATUS, 32'h1);
    rdc(`DDRH_OFS_CFG, 32'h0);
    wb(1'b1, 8'h1c, 32'hffffffff, 4'hf);
    rdc(8'h1c, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      v = rnd();
      wb(1'b1, 8'(8 + 4 * i), v, 4'hf);
      wb(1'b1, 8'(8 + 4 * i), ~v, 4'h2);
      rdc(8'(8 + 4 * i), {16'h0, ~v[15:8], v[7:0]});
    end
    wb(1'b1, `DDRH_OFS_CFG, 32'h1, 4'h1);
    rdc(`DDRH_OFS_CFG, 32'h1);
    $display("Test registers done");
    for (int i = 0; i < 6; i++)
    begin
      v = rnd();
      a = v[4:0];
      n = i == 0 ? 0 : i == 1 ? 7 : v[10:8];
      mst.slow = i[0];
      axw(1'b1);
      axw(1'b0);
      axr();
      axr();
    end
    $display("Test data port done");
    for (int i = 0; i < 4; i++)
    begin
      e = rq[i] == 2'h3 ? 2'h0 : rq[i];
      wb(1'b1, `DDRH_OFS_CTRL, {16'h0, rq[i], 13'h0, 1'b1}, 4'h3);
      repeat (2) @(posedge clk);
      rdc(`DDRH_OFS_STATUS, {28'h0, ps, 2'b10});
      p = 0;
      do wb(1'b0, `DDRH_OFS_STATUS, 32'h0, 4'hf); while (!wb_q[0] && ++p < 40);
      if (p >= 40)
        n_mismatch++;
      rdc(`DDRH_OFS_STATUS, {28'h0, e, 2'b01});
      chk({31'h0, st}, {31'h0, e});
      if (e == 2'h1)
        chk({31'h0, awr, arr}, 33'h0);
      ps = e;
    end
    chk(33'(n_mrl), 33'h1);
    $display("Test state switching done");
    if (mst.tmo)
      n_mismatch++;
    end_of_test();
  end
endmodule
